/* File: logic/frc_defs.vh */
// constants of the read-command executor: opcodes, byte slots, status bits, timing
// assumes inclusion by the design files only; definitions, no logic
`ifndef FRC_DEFS_VH
`define FRC_DEFS_VH

// opcode field and flag bits of the first command byte
`define FRC_OP_LSB 0
`define FRC_OP_MSB 4
`define FRC_OP_READ_DATA 5'h06
`define FRC_OP_READ_DEL 5'h0c
`define FRC_OP_READ_TRACK 5'h02
`define FRC_OP_READ_ID 5'h0a
`define FRC_B0_SKIP 5
`define FRC_B0_DDEN 6
`define FRC_B0_MULTI 7

// second command byte
`define FRC_B1_DS_LSB 0
`define FRC_B1_DS_MSB 1
`define FRC_B1_HEAD 2
`define FRC_B1_SEEK 7

// command lengths and byte slots
`define FRC_LEN_LONG 4'h9
`define FRC_LEN_SHORT 4'h2
`define FRC_SLOT_TRACK 4'h2
`define FRC_SLOT_HNUM 4'h3
`define FRC_SLOT_SECT 4'h4
`define FRC_SLOT_SIZE 4'h5
`define FRC_SLOT_LAST 4'h6

// interrupt code field of status 0
`define FRC_IC_NORMAL 2'h0
`define FRC_IC_ABNORMAL 2'h1
`define FRC_IC_INVALID 2'h2

// status 1 bits
`define FRC_SR1_EN 7
`define FRC_SR1_CE 5
`define FRC_SR1_OR 4
`define FRC_SR1_NM 2
`define FRC_SR1_MISS 0

// status 2 bits
`define FRC_SR2_CTL 6
`define FRC_SR2_DCE 5
`define FRC_SR2_WT 4
`define FRC_SR2_BT 1
`define FRC_SR2_MD 0

`define FRC_TRACK_BAD 8'hff
`define FRC_RES_LEN 3'h7
`define FRC_RES_LEN_INV 3'h1
`define FRC_ZERO8 8'h00
`define FRC_ONE8 8'h01

// data stream buffer
`define FRC_FIFO_WIDTH 8
`define FRC_FIFO_DEPTH 32
`define FRC_FIFO_AW 5

// motor-on delay: time in microseconds, clock in MHz
`define FRC_MOTOR_ON_US 1000
`define FRC_CLK_MHZ 100

`endif

/* File: logic/frc_fifo.v */
// synchronous FIFO between the disk byte stream and the host data port
// assumes one clock; push and pop obey valid and ready on each side
`timescale 1ns/1ps
module frc_fifo #(
  parameter WIDTH = 8,
  parameter DEPTH = 32,
  parameter AW = 5
) (
  input wire clk_sys,
  input wire rst_n,
  input wire in_valid,
  input wire [WIDTH-1:0] in_data,
  output wire in_ready,
  output wire out_valid,
  output wire [WIDTH-1:0] out_data,
  input wire out_ready
);
  reg [WIDTH-1:0] mem_q [0:DEPTH-1];
  reg [AW-1:0] wr_q;
  reg [AW-1:0] rd_q;
  reg [AW:0] cnt_q;
  wire push;
  wire pop;

  assign in_ready = (cnt_q != DEPTH[AW:0]);
  assign out_valid = (cnt_q != {(AW+1){1'b0}});
  assign out_data = mem_q[rd_q];
  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;

  always @(posedge clk_sys) begin
    if (push) begin
      mem_q[wr_q] <= in_data;
    end
  end

  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      wr_q <= {AW{1'b0}};
      rd_q <= {AW{1'b0}};
      cnt_q <= {(AW+1){1'b0}};
    end else begin
      // depth is a power of two, so the pointers wrap by themselves
      if (push) begin
        wr_q <= wr_q + 1'b1;
      end
      if (pop) begin
        rd_q <= rd_q + 1'b1;
      end
      if (push && !pop) begin
        cnt_q <= cnt_q + 1'b1;
      end else if (pop && !push) begin
        cnt_q <= cnt_q - 1'b1;
      end
    end
  end
endmodule

/* File: logic/frc_motor_timer.v */
// motor-on delay counter: runs while enabled, done pulses once at the end
// assumes the enable drops after done; a new enable restarts from zero
`timescale 1ns/1ps
module frc_motor_timer #(
  parameter CYCLES = 100000
) (
  input wire clk_sys,
  input wire rst_n,
  input wire enable,
  output wire done
);
  reg [23:0] cnt_q;

  assign done = enable && (cnt_q == CYCLES[23:0] - 24'h000001);

  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q <= 24'h000000;
    end else if (!enable || done) begin
      cnt_q <= 24'h000000;
    end else begin
      cnt_q <= cnt_q + 24'h000001;
    end
  end
endmodule

/* File: logic/frc_read_exec.v */
// executor for read data, read deleted data, read id and read a track
// assumes separator inputs are one-cycle pulses synchronous to clk_sys;
// seeking itself is done by an outside unit via seek_req and seek_done
`timescale 1ns/1ps
`include "frc_defs.vh"

// Behaviour
// - read data: nine bytes, opcode 00110
// - read deleted: same layout, opcode 01100
// - read track: nine bytes, opcode 00010
// - read id: two bytes, opcode 01010
// - read data: deleted mark sets mark bit
// - read deleted: normal mark sets mark bit
// - read deleted otherwise equals read data
// - below final sector: result sector plus one; read track on terminal count keeps the sector read
// - at final sector: sector 1, track/head advance; read track keeps the final sector
// - read id returns first found id
// - motor-on delay timed before searching
// - read id never seeks
// - read id error: abnormal, result phase
// - host byte during search aborts command
// - two index pulses, no mark: missing-mark
// - read track waits index; early write aborts
// - read track: no sector compare, counter
// - read track: mismatch/checksum flagged, sector read
// - read track: data checksum flagged, continues
// - read track: at most final-sector-number sectors
// - terminal count normal; final sector abnormal
module frc_read_exec #(
  parameter MOTOR_ON_CYC = `FRC_MOTOR_ON_US * `FRC_CLK_MHZ
) (
  input wire clk_sys,
  input wire rst_n,
  input wire cmd_valid,
  input wire [7:0] cmd_byte,
  output wire cmd_ready,
  output wire res_valid,
  output wire [7:0] res_byte,
  input wire res_ready,
  output wire dat_valid,
  output wire [7:0] dat_byte,
  input wire dat_ready,
  input wire terminal_count,
  output wire seek_req,
  input wire seek_done,
  output wire sep_enable,
  output wire double_density_flag,
  output wire head_select,
  output wire drive_sel_hi,
  output wire drive_sel_lo,
  input wire idx_pulse,
  input wire am_found,
  input wire id_crc_err,
  input wire [7:0] id_track,
  input wire [7:0] id_head,
  input wire [7:0] id_sector,
  input wire [7:0] id_size,
  input wire data_mark_found,
  input wire data_deleted,
  input wire data_mark_missing,
  input wire sec_byte_valid,
  input wire [7:0] sec_byte,
  input wire sec_end,
  input wire sec_crc_err,
  output wire busy,
  output wire int_req
);
  localparam S_IDLE = 10'h001;
  localparam S_CMD = 10'h002;
  localparam S_MOTOR = 10'h004;
  localparam S_SEEK = 10'h008;
  localparam S_IDXW = 10'h010;
  localparam S_SRCH = 10'h020;
  localparam S_DWAIT = 10'h040;
  localparam S_XFER = 10'h080;
  localparam S_FIN = 10'h100;
  localparam S_RES = 10'h200;

  reg [9:0] state_q;
  reg [3:0] bidx_q;
  reg [4:0] op_q;
  reg multi_side_flag_q, dd_q, skip_deleted_flag_q, implied_seek_flag_q;
  reg head_q;
  reg [1:0] ds_q;
  reg [7:0] trk_q, hnum_q, sec_q, size_q, last_q;
  reg [7:0] sr1_q, sr2_q;
  reg [1:0] ic_q;
  reg [1:0] idx_cnt_q;
  reg am_seen_q, wt_q, bt_q, nm_q;
  reg stop_after_q, tc_q;
  reg [55:0] res_sh_q;
  reg [2:0] res_left_q;
  reg irq_q;

  wire is_track = (op_q == `FRC_OP_READ_TRACK);
  wire is_id = (op_q == `FRC_OP_READ_ID);
  wire is_del = (op_q == `FRC_OP_READ_DEL);
  wire [4:0] new_op = cmd_byte[`FRC_OP_MSB:`FRC_OP_LSB];
  wire new_long = (new_op == `FRC_OP_READ_DATA) || (new_op == `FRC_OP_READ_DEL) ||
                  (new_op == `FRC_OP_READ_TRACK);
  wire new_known = new_long || (new_op == `FRC_OP_READ_ID);
  wire [3:0] cmd_len = is_id ? `FRC_LEN_SHORT : `FRC_LEN_LONG;
  wire searching = (state_q == S_SRCH) || (state_q == S_DWAIT) || (state_q == S_IDXW);

  wire mot_done;
  wire fifo_in_ready;
  wire fifo_push = (state_q == S_XFER) && sec_byte_valid;

  wire at_last = (sec_q == last_q);
  wire side_swap = multi_side_flag_q && !head_q;
  wire [7:0] adv_sec = at_last ? `FRC_ONE8 : sec_q + `FRC_ONE8;
  // wrap to sector 1, head or track step
  wire [7:0] adv_trk = (at_last && !side_swap) ? trk_q + `FRC_ONE8 : trk_q;
  wire adv_head = at_last ? (multi_side_flag_q ? !head_q : head_q) : head_q;
  wire [7:0] adv_hnum = (at_last && multi_side_flag_q) ? {7'h00, !head_q} : hnum_q;

  wire id_match = (id_track == trk_q) && (id_head == hnum_q) && (id_size == size_q) &&
                  (is_track || (id_sector == sec_q));
  wire mark_wanted = is_del ? data_deleted : !data_deleted;
  wire [7:0] sr0 = {ic_q, 3'h0, head_q, ds_q};

  // ordered command intake, ordered result bytes
  assign cmd_ready = (state_q == S_IDLE) || (state_q == S_CMD) || searching;
  assign res_valid = (state_q == S_RES);
  assign res_byte = res_sh_q[55:48];
  assign seek_req = (state_q == S_SEEK);
  assign sep_enable = (state_q == S_SRCH) || (state_q == S_DWAIT) || (state_q == S_XFER) ||
                      (state_q == S_IDXW);
  assign double_density_flag = dd_q;
  assign head_select = head_q;
  assign drive_sel_hi = ds_q[1];
  assign drive_sel_lo = ds_q[0];
  assign busy = !(state_q == S_IDLE);
  assign int_req = irq_q;

  frc_motor_timer #(
    .CYCLES(MOTOR_ON_CYC)
  ) u_motor (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .enable(state_q == S_MOTOR),
    .done(mot_done)
  );

  frc_fifo #(
    .WIDTH(`FRC_FIFO_WIDTH),
    .DEPTH(`FRC_FIFO_DEPTH),
    .AW(`FRC_FIFO_AW)
  ) u_fifo (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .in_valid(fifo_push),
    .in_data(sec_byte),
    .in_ready(fifo_in_ready),
    .out_valid(dat_valid),
    .out_data(dat_byte),
    .out_ready(dat_ready)
  );

  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= S_IDLE;
      bidx_q <= 4'h0;
      op_q <= 5'h00;
      multi_side_flag_q <= 1'b0;
      dd_q <= 1'b0;
      skip_deleted_flag_q <= 1'b0;
      implied_seek_flag_q <= 1'b0;
      head_q <= 1'b0;
      ds_q <= 2'h0;
      trk_q <= 8'h00;
      hnum_q <= 8'h00;
      sec_q <= 8'h00;
      size_q <= 8'h00;
      last_q <= 8'h00;
      sr1_q <= 8'h00;
      sr2_q <= 8'h00;
      ic_q <= `FRC_IC_NORMAL;
      idx_cnt_q <= 2'h0;
      am_seen_q <= 1'b0;
      wt_q <= 1'b0;
      bt_q <= 1'b0;
      nm_q <= 1'b0;
      stop_after_q <= 1'b0;
      tc_q <= 1'b0;
      res_sh_q <= 56'h0;
      res_left_q <= 3'h0;
      irq_q <= 1'b0;
    end else begin
      case (state_q)
        S_IDLE: begin
          if (cmd_valid) begin
            op_q <= new_op;
            multi_side_flag_q <= cmd_byte[`FRC_B0_MULTI];
            dd_q <= cmd_byte[`FRC_B0_DDEN];
            skip_deleted_flag_q <= cmd_byte[`FRC_B0_SKIP];
            sr1_q <= 8'h00;
            sr2_q <= 8'h00;
            ic_q <= `FRC_IC_NORMAL;
            tc_q <= 1'b0;
            stop_after_q <= 1'b0;
            bidx_q <= 4'h1;
            if (new_known) begin
              state_q <= S_CMD;
            end else begin
              // unknown opcode answers with one status byte only
              ic_q <= `FRC_IC_INVALID;
              // no head or drive of an older command in the lone status byte
              head_q <= 1'b0;
              ds_q <= 2'h0;
              state_q <= S_FIN;
            end
          end
        end
        S_CMD: begin
          if (cmd_valid) begin
            bidx_q <= bidx_q + 4'h1;
            case (bidx_q)
              4'h1: begin
                // head and drive bits share the second byte
                ds_q <= cmd_byte[`FRC_B1_DS_MSB:`FRC_B1_DS_LSB];
                head_q <= cmd_byte[`FRC_B1_HEAD];
                implied_seek_flag_q <= cmd_byte[`FRC_B1_SEEK];
              end
              `FRC_SLOT_TRACK: trk_q <= cmd_byte;
              `FRC_SLOT_HNUM: hnum_q <= cmd_byte;
              `FRC_SLOT_SECT: sec_q <= cmd_byte;
              `FRC_SLOT_SIZE: size_q <= cmd_byte;
              `FRC_SLOT_LAST: last_q <= cmd_byte;
              default: begin
                // gap and data length bytes are accepted and ignored
              end
            endcase
            if (bidx_q == cmd_len - 4'h1) begin
              state_q <= S_MOTOR;
            end
          end
        end
        S_MOTOR: begin
          if (mot_done) begin
            idx_cnt_q <= 2'h0;
            am_seen_q <= 1'b0;
            wt_q <= 1'b0;
            bt_q <= 1'b0;
            nm_q <= 1'b0;
            // read id skips any implied seek
            if (implied_seek_flag_q && !is_id) begin
              state_q <= S_SEEK;
            end else if (is_track) begin
              state_q <= S_IDXW;
            end else begin
              state_q <= S_SRCH;
            end
          end
        end
        S_SEEK: begin
          if (seek_done) begin
            state_q <= is_track ? S_IDXW : S_SRCH;
          end
        end
        S_IDXW: begin
          // early host byte ends the command
          if (cmd_valid) begin
            ic_q <= `FRC_IC_ABNORMAL;
            state_q <= S_FIN;
          end else if (idx_pulse) begin
            // track counter starts at sector 1
            sec_q <= `FRC_ONE8;
            state_q <= S_SRCH;
          end
        end
        S_SRCH: begin
          if (cmd_valid) begin
            ic_q <= `FRC_IC_ABNORMAL;
            state_q <= S_FIN;
          end else if (am_found) begin
            am_seen_q <= 1'b1;
            if (is_id) begin
              // first address field is the answer
              if (id_crc_err) begin
                sr1_q[`FRC_SR1_CE] <= 1'b1;
                ic_q <= `FRC_IC_ABNORMAL;
              end else begin
                trk_q <= id_track;
                hnum_q <= id_head;
                sec_q <= id_sector;
                size_q <= id_size;
              end
              state_q <= S_FIN;
            end else if (is_track) begin
              // flag and still read the sector
              if (id_crc_err) begin
                sr1_q[`FRC_SR1_CE] <= 1'b1;
              end
              if (!id_match) begin
                sr1_q[`FRC_SR1_NM] <= 1'b1;
              end
              state_q <= S_DWAIT;
            end else if (id_crc_err) begin
              sr1_q[`FRC_SR1_CE] <= 1'b1;
              ic_q <= `FRC_IC_ABNORMAL;
              state_q <= S_FIN;
            end else if (id_match) begin
              state_q <= S_DWAIT;
            end else if (id_track != trk_q) begin
              if (id_track == `FRC_TRACK_BAD) begin
                bt_q <= 1'b1;
              end else begin
                wt_q <= 1'b1;
              end
            end else begin
              nm_q <= 1'b1;
            end
          end else if (idx_pulse) begin
            // second index without a matching id ends the search
            if (idx_cnt_q == 2'h1) begin
              ic_q <= `FRC_IC_ABNORMAL;
              state_q <= S_FIN;
              if (!am_seen_q) begin
                sr1_q[`FRC_SR1_MISS] <= 1'b1;
              end
              // keep a mismatch already flagged by a track read
              sr1_q[`FRC_SR1_NM] <= sr1_q[`FRC_SR1_NM] | nm_q;
              sr2_q[`FRC_SR2_WT] <= wt_q;
              sr2_q[`FRC_SR2_BT] <= bt_q;
            end else begin
              idx_cnt_q <= idx_cnt_q + 2'h1;
            end
          end
        end
        S_DWAIT: begin
          if (cmd_valid) begin
            ic_q <= `FRC_IC_ABNORMAL;
            state_q <= S_FIN;
          end else if (data_mark_missing) begin
            sr2_q[`FRC_SR2_MD] <= 1'b1;
            ic_q <= `FRC_IC_ABNORMAL;
            state_q <= S_FIN;
          end else if (data_mark_found) begin
            // mark bit follows the wanted mark
            if (is_track || mark_wanted) begin
              sr2_q[`FRC_SR2_CTL] <= 1'b0;
              state_q <= S_XFER;
            end else begin
              sr2_q[`FRC_SR2_CTL] <= 1'b1;
              if (skip_deleted_flag_q) begin
                // skipped sector: on to the next one, unread
                sec_q <= adv_sec;
                trk_q <= adv_trk;
                head_q <= adv_head;
                hnum_q <= adv_hnum;
                idx_cnt_q <= 2'h0;
                state_q <= S_SRCH;
              end else begin
                stop_after_q <= 1'b1;
                state_q <= S_XFER;
              end
            end
          end
        end
        S_XFER: begin
          if (terminal_count) begin
            tc_q <= 1'b1;
          end
          // the disk cannot wait, so a full buffer is an overrun
          if (sec_byte_valid && !fifo_in_ready) begin
            sr1_q[`FRC_SR1_OR] <= 1'b1;
            ic_q <= `FRC_IC_ABNORMAL;
            state_q <= S_FIN;
          end else if (sec_end) begin
            idx_cnt_q <= 2'h0;
            am_seen_q <= 1'b0;
            if (is_track) begin
              // data checksum flagged, reading goes on
              if (sec_crc_err) begin
                sr1_q[`FRC_SR1_CE] <= 1'b1;
                sr2_q[`FRC_SR2_DCE] <= 1'b1;
              end
              // stop after the final sector count
              if (tc_q || terminal_count) begin
                state_q <= S_FIN;
              end else if (at_last) begin
                sr1_q[`FRC_SR1_EN] <= 1'b1;
                ic_q <= `FRC_IC_ABNORMAL;
                state_q <= S_FIN;
              end else begin
                sec_q <= sec_q + `FRC_ONE8;
                state_q <= S_SRCH;
              end
            end else if (sec_crc_err) begin
              sr1_q[`FRC_SR1_CE] <= 1'b1;
              sr2_q[`FRC_SR2_DCE] <= 1'b1;
              ic_q <= `FRC_IC_ABNORMAL;
              state_q <= S_FIN;
            end else begin
              sec_q <= adv_sec;
              trk_q <= adv_trk;
              head_q <= adv_head;
              hnum_q <= adv_hnum;
              // count ends normally, final sector abnormally
              if (tc_q || terminal_count || stop_after_q) begin
                state_q <= S_FIN;
              end else if (at_last && !side_swap) begin
                sr1_q[`FRC_SR1_EN] <= 1'b1;
                ic_q <= `FRC_IC_ABNORMAL;
                state_q <= S_FIN;
              end else begin
                state_q <= S_SRCH;
              end
            end
          end
        end
        S_FIN: begin
          res_sh_q <= {sr0, sr1_q, sr2_q, trk_q, hnum_q, sec_q, size_q};
          res_left_q <= (ic_q == `FRC_IC_INVALID) ? `FRC_RES_LEN_INV : `FRC_RES_LEN;
          irq_q <= 1'b1;
          state_q <= S_RES;
        end
        S_RES: begin
          if (res_ready) begin
            // interrupt stands until the host starts reading results
            irq_q <= 1'b0;
            res_sh_q <= {res_sh_q[47:0], `FRC_ZERO8};
            res_left_q <= res_left_q - 3'h1;
            if (res_left_q == 3'h1) begin
              state_q <= S_IDLE;
            end
          end
        end
        default: begin
          state_q <= S_IDLE;
        end
      endcase
    end
  end
endmodule

/* File: verif/frc_monitor.sv */
// port checker for the read-command executor
// assumes bound into frc_read_exec; one clock, async active-low reset
`timescale 1ns/1ps
module frc_monitor #(
  parameter MOTOR_ON_CYC = 4
) (
  input wire clk_sys,
  input wire rst_n,
  input wire cmd_valid,
  input wire [7:0] cmd_byte,
  input wire cmd_ready,
  input wire res_valid,
  input wire [7:0] res_byte,
  input wire res_ready,
  input wire dat_valid,
  input wire [7:0] dat_byte,
  input wire dat_ready,
  input wire seek_req,
  input wire sep_enable,
  input wire busy,
  input wire int_req
);
  reg [7:0] b0_q;
  reg [31:0] low_q;

  // first byte of each command, and length of the quiet gap before the search
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      b0_q <= 8'h00;
      low_q <= 32'h0;
    end else begin
      if (!busy && cmd_valid && cmd_ready)
        b0_q <= cmd_byte;
      if (!busy || sep_enable || cmd_ready || res_valid)
        low_q <= 32'h0;
      else
        low_q <= low_q + 32'h1;
    end
  end

  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  a_int_with_res: assert property ($rose(res_valid) |-> int_req)
    else $error("result phase began without interrupt");
  a_int_take_clr: assert property (res_valid && res_ready && int_req |=> !int_req)
    else $error("interrupt not cleared by first result take");
  a_res_byte_hold: assert property (res_valid && !res_ready |=> res_valid && $stable(res_byte))
    else $error("result byte changed before it was taken");
  a_res_refuses_cmd: assert property (res_valid |-> !cmd_ready && !sep_enable)
    else $error("command or separator active in result phase");
  a_idle_is_quiet: assert property (!busy |-> cmd_ready && !res_valid && !seek_req)
    else $error("idle state not clean");
  a_id_no_seek: assert property (busy && b0_q[4:0] == 5'h0a |-> !seek_req)
    else $error("read id requested a seek");
  a_motor_first: assert property (
    $rose(sep_enable) |-> low_q >= MOTOR_ON_CYC)
    else $error("search began before the motor-on delay");
  a_abort_result: assert property (cmd_valid && cmd_ready && sep_enable |-> ##2 res_valid)
    else $error("host byte during search did not abort");
  a_dat_hold: assert property (dat_valid && !dat_ready |=> dat_valid && $stable(dat_byte))
    else $error("stream byte dropped while stalled");
endmodule

bind frc_read_exec frc_monitor #(.MOTOR_ON_CYC(MOTOR_ON_CYC)) u_mon (.clk_sys(clk_sys),
  .rst_n(rst_n), .cmd_valid(cmd_valid), .cmd_byte(cmd_byte), .cmd_ready(cmd_ready),
  .res_valid(res_valid), .res_byte(res_byte), .res_ready(res_ready),
  .dat_valid(dat_valid), .dat_byte(dat_byte), .dat_ready(dat_ready),
  .seek_req(seek_req), .sep_enable(sep_enable), .busy(busy), .int_req(int_req));

/* File: verif/frc_host_model.sv */
// host-side sink of the read stream, with a stall control
// assumes the stream handshakes on the rising edge of clk_sys
`timescale 1ns/1ps
module frc_host_model (
  input wire clk_sys,
  input wire rst_n,
  input wire dat_valid,
  input wire [7:0] dat_byte,
  input wire stall,
  output logic dat_ready,
  output int n_got
);
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      dat_ready <= 1'b0;
      n_got <= 0;
    end else begin
      dat_ready <= !stall;
      if (dat_valid && dat_ready)
        n_got <= n_got + 1;
    end
  end
endmodule

/* File: verif/frc_read_exec_test.sv */
// testbench of the read-command executor
// assumes a short motor delay; disk side driven as one-cycle pulses
`timescale 1ns/1ps
module frc_read_exec_test;
  logic clk_sys, rst_n, cmd_valid, res_ready, terminal_count, stall;
  logic id_crc_err, data_deleted, sec_crc_err;
  logic [7:0] cmd_byte, id_track, id_head, id_sector, id_size, sec_byte;
  logic [4:0] pl;
  wire cmd_ready, res_valid, dat_valid, dat_ready, seek_req, sep_enable, busy, int_req;
  wire [7:0] res_byte, dat_byte;
  int n_got, n_fail, checks, base, i;

  frc_read_exec #(.MOTOR_ON_CYC(4)) dut (.clk_sys(clk_sys), .rst_n(rst_n),
    .cmd_valid(cmd_valid), .cmd_byte(cmd_byte), .cmd_ready(cmd_ready),
    .res_valid(res_valid), .res_byte(res_byte), .res_ready(res_ready),
    .dat_valid(dat_valid), .dat_byte(dat_byte), .dat_ready(dat_ready),
    .terminal_count(terminal_count), .seek_req(seek_req), .seek_done(1'b0),
    .sep_enable(sep_enable), .double_density_flag(), .head_select(),
    .drive_sel_hi(), .drive_sel_lo(), .idx_pulse(pl[0]), .am_found(pl[1]),
    .id_crc_err(id_crc_err), .id_track(id_track), .id_head(id_head),
    .id_sector(id_sector), .id_size(id_size), .data_mark_found(pl[2]),
    .data_deleted(data_deleted), .data_mark_missing(1'b0), .sec_byte_valid(pl[3]),
    .sec_byte(sec_byte), .sec_end(pl[4]), .sec_crc_err(sec_crc_err),
    .busy(busy), .int_req(int_req));
  frc_host_model host (.clk_sys(clk_sys), .rst_n(rst_n), .dat_valid(dat_valid),
    .dat_byte(dat_byte), .stall(stall), .dat_ready(dat_ready), .n_got(n_got));

  initial begin
    clk_sys = 0;
    forever #5 clk_sys = ~clk_sys;
  end

  task tick;
    @(posedge clk_sys);
    #1;
  endtask
  task chk(input string s, input [31:0] e, input [31:0] g);
    checks++;
    if (e !== g) begin
      n_fail++;
      $display("[FAIL] %s exp %h got %h", s, e, g);
    end
  endtask
  task report_and_stop;
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task cmd(input [71:0] b, input int n);
    int k, w;
    for (k = 0; k < n; k++) begin
      cmd_byte = b[71-8*k -: 8];
      cmd_valid = 1;
      w = 0;
      while (cmd_ready !== 1'b1 && w < 50) begin
        tick;
        w++;
      end
      chk("cmd_ready", 1, cmd_ready);
      tick;
    end
    cmd_valid = 0;
  endtask
  // drive 1, head 0, track 05, size 02, gap 1b, length ff
  task rcmd(input [7:0] op, input [7:0] s, input [7:0] last);
    cmd({op, 8'h01, 8'h05, 8'h00, s, 8'h02, last, 8'h1b, 8'hff}, 9);
  endtask
  task wsep;
    int w;
    w = 0;
    while (sep_enable !== 1'b1 && w < 200) begin
      tick;
      w++;
    end
    chk("sep_enable", 1, sep_enable);
  endtask
  task pulse(input [4:0] m);
    pl = m;
    tick;
    pl = 0;
    tick;
  endtask
  task sect(input [7:0] s, input int nb);
    int k;
    id_sector = s;
    pulse(5'h02);
    pulse(5'h04);
    for (k = 0; k < nb; k++) begin
      sec_byte = 8'ha0 + k[7:0];
      pulse(5'h08);
    end
    pulse(5'h10);
  endtask
  task res(input [55:0] e, input int k, input int t);
    int j, w;
    w = 0;
    while (res_valid !== 1'b1 && w < 400) begin
      tick;
      w++;
    end
    chk("res_valid", 1, res_valid);
    tick;
    res_ready = 1;
    for (j = 0; j < t; j++) begin
      if (j < k)
        chk("res_byte", e[55-8*j -: 8], res_byte);
      tick;
    end
    res_ready = 0;
    chk("busy", 0, busy);
  endtask
  task fin(input string s);
    $display("test %s done", s);
  endtask

  initial begin
    #100000;
    n_fail++;
    report_and_stop;
  end

  initial begin
    {cmd_valid, res_ready, terminal_count, stall} = 4'h0;
    {id_crc_err, data_deleted, sec_crc_err} = 3'h0;
    cmd_byte = 8'h00;
    pl = 5'h00;
    sec_byte = 8'h00;
    id_track = 8'h05;
    id_head = 8'h00;
    id_sector = 8'h00;
    id_size = 8'h02;
    n_fail = 0;
    checks = 0;
    rst_n = 0;
    repeat (6) @(posedge clk_sys);
    #1;
    rst_n = 1;
    base = n_got;
    rcmd(8'h06, 8'h03, 8'h03);
    wsep;
    sect(8'h03, 4);
    res(56'h41_80_00_06_00_01_02, 7, 7);
    chk("n_got", base + 4, n_got);
    fin("final_sector");
    rcmd(8'h06, 8'h03, 8'h05);
    wsep;
    terminal_count = 1;
    sect(8'h03, 4);
    terminal_count = 0;
    res(56'h01_00_00_05_00_04_02, 7, 7);
    fin("terminal_count");
    for (i = 0; i < 2; i++) begin
      data_deleted = (i == 0);
      rcmd(i ? 8'h0c : 8'h06, 8'h02, 8'h05);
      wsep;
      sect(8'h02, 2);
      res(56'h01_00_40_05_00_03_02, 7, 7);
    end
    data_deleted = 0;
    fin("control_mark");
    base = n_got;
    data_deleted = 1;
    rcmd(8'h26, 8'h02, 8'h05);
    wsep;
    sect(8'h02, 0);
    data_deleted = 0;
    terminal_count = 1;
    sect(8'h03, 1);
    terminal_count = 0;
    res(56'h01_00_00_05_00_04_02, 7, 7);
    chk("n_got", base + 1, n_got);
    rcmd(8'h86, 8'h05, 8'h05);
    wsep;
    sect(8'h05, 1);
    id_head = 8'h01;
    terminal_count = 1;
    sect(8'h01, 1);
    terminal_count = 0;
    id_head = 8'h00;
    res(56'h05_00_00_05_01_02_02, 7, 7);
    fin("skip_multi");
    id_track = 8'h07;
    id_head = 8'h01;
    cmd({8'h4a, 8'h81, 56'h0}, 2);
    wsep;
    id_sector = 8'h09;
    pulse(5'h02);
    res(56'h01_00_00_07_01_09_02, 7, 7);
    id_track = 8'h05;
    id_head = 8'h00;
    cmd({8'h0a, 8'h01, 56'h0}, 2);
    wsep;
    pulse(5'h01);
    pulse(5'h01);
    res({24'h41_01_00, 32'h0}, 3, 7);
    cmd({8'h0a, 8'h01, 56'h0}, 2);
    wsep;
    cmd({8'h00, 64'h0}, 1);
    res({8'h41, 48'h0}, 1, 7);
    fin("read_id");
    rcmd(8'h02, 8'h01, 8'h01);
    wsep;
    cmd({8'h00, 64'h0}, 1);
    res({8'h41, 48'h0}, 1, 7);
    rcmd(8'h42, 8'h01, 8'h01);
    wsep;
    pulse(5'h01);
    id_head = 8'h01;
    sec_crc_err = 1;
    sect(8'h09, 2);
    sec_crc_err = 0;
    id_head = 8'h00;
    res({24'h41_a4_20, 32'h0}, 3, 7);
    fin("read_track");
    stall = 1;
    base = n_got;
    rcmd(8'h06, 8'h03, 8'h05);
    wsep;
    sect(8'h03, 33);
    res({16'h41_10, 40'h0}, 2, 7);
    stall = 0;
    repeat (40) tick;
    chk("n_got", base + 32, n_got);
    fin("overrun");
    cmd({8'h1f, 64'h0}, 1);
    res({8'h80, 48'h0}, 1, 1);
    fin("invalid");
    report_and_stop;
  end
endmodule
